// >>> four_port_parallel_io_tb_top.sv
// Self-checking testbench of the four-port parallel I/O block
`timescale 1ns/100ps
`default_nettype none

module four_port_parallel_io_tb_top;
  import fpp_pkg::*;
  logic       mclk, rst_n, sfr_wr, sfr_rd, sfr_ack, uart_rxd;
  logic [7:0] sfr_addr;
  fpp_byte_t  sfr_wdata, sfr_rdata;
  logic       xmem_p0_drive, xmem_p2_drive, xmem_strobe_en;
  logic       xmem_wr_n, xmem_rd_n, uart_en, uart_txd;
  logic       uart_rxd_oe, uart_rxd_out;
  logic [7:0] xmem_p0_data, xmem_p2_addr, port_one_analog_sel;
  logic       third_timer_count_input, third_timer_capture_trigger;
  logic       spi_slave_select_n, ext_interrupt_zero, ext_interrupt_one;
  logic       first_timer_count_input, second_timer_count_input;
  logic [7:0] p0_in, p0_out, p0_oe_n, p1_in, p2_in, p2_out, p2_oe_n;
  logic [7:0] p3_in, p3_out, p3_oe_n, ext0, ext2, ext3, w, r1, r3;
  logic [7:0] lat [4];
  logic [7:0] addr_t [4];
  logic [6:0] periph;
  int         miscompares, n_checks;

  assign addr_t = '{FPP_ADDR_PORT0, FPP_ADDR_PORT1, FPP_ADDR_PORT2,
                    FPP_ADDR_PORT3};
  assign periph = {third_timer_count_input, third_timer_capture_trigger,
                   spi_slave_select_n, ext_interrupt_zero, ext_interrupt_one,
                   first_timer_count_input, second_timer_count_input};

  fpp_ports dut_u (.mclk, .rst_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
    .sfr_rdata, .sfr_ack, .xmem_p0_drive, .xmem_p0_data, .xmem_p2_drive,
    .xmem_p2_addr, .xmem_strobe_en, .xmem_wr_n, .xmem_rd_n, .uart_en,
    .uart_txd, .uart_rxd_oe, .uart_rxd_out, .uart_rxd,
    .third_timer_count_input, .third_timer_capture_trigger,
    .spi_slave_select_n, .ext_interrupt_zero, .ext_interrupt_one,
    .first_timer_count_input, .second_timer_count_input,
    .port_one_analog_sel, .p0_in, .p0_out, .p0_oe_n, .p1_in, .p2_in,
    .p2_out, .p2_oe_n, .p3_in, .p3_out, .p3_oe_n);

  fpp_ext_model ext_u (.p0_out, .p0_oe_n, .p2_out, .p2_oe_n, .p3_out,
    .p3_oe_n, .ext0, .ext2, .ext3, .p0_in, .p2_in, .p3_in);

  // ------------------------------------------------------------
  // Checking and bus tasks
  // ------------------------------------------------------------
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : cmp_byte

  task automatic cmp_ack(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected ack at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : cmp_ack

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    sfr_wr    <= 1'b1;
    sfr_addr  <= a;
    sfr_wdata <= d;
    @(posedge mclk);
    sfr_wr    <= 1'b0;
  endtask : reg_wr

  // Answer stands one cycle only, so sample right after that edge
  task automatic reg_rd(input logic [7:0] a, input logic ack,
                        input logic [7:0] d);
    @(posedge mclk);
    sfr_rd   <= 1'b1;
    sfr_addr <= a;
    @(posedge mclk);
    sfr_rd   <= 1'b0;
    #1;
    cmp_ack(sfr_ack, ack);
    cmp_byte(sfr_rdata, d);
  endtask : reg_rd

  // Pin filter needs three edges plus agreement
  task automatic settle();
    repeat (8) @(posedge mclk);
    #1;
  endtask : settle

  function automatic logic [7:0] exp_pin(input int k);
    case (k)
      0: return lat[0] & ext0;
      1: return p1_in;
      2: return lat[2] & ext2;
      default: return lat[3] & ext3;
    endcase
  endfunction : exp_pin

  task automatic results();
    if (miscompares == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results

  // ------------------------------------------------------------
  // Clock, watchdog, stimulus
  // ------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  initial begin
    #20000;
    miscompares++;
    results();
  end

  initial begin
    {rst_n, sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = '0;
    {xmem_p0_drive, xmem_p2_drive, xmem_strobe_en, uart_en} = '0;
    {uart_txd, uart_rxd_oe, uart_rxd_out, xmem_p0_data, xmem_p2_addr} = '0;
    {xmem_wr_n, xmem_rd_n} = 2'b11;
    {p1_in, ext0, ext2, ext3} = {8'h00, 8'hFF, 8'hFF, 8'hFF};
    for (int k = 0; k < 4; k++) lat[k] = 8'hFF;
    void'($urandom(32'h29192296));
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    settle();
    cmp_byte(p0_oe_n, 8'hFF);
    cmp_byte(port_one_analog_sel, 8'hFF);
    for (int k = 0; k < 4; k++) reg_rd(addr_t[k], 1'b1, exp_pin(k));
    // Random latch values against random outside levels
    for (int i = 0; i < 16; i++) begin
      w = $urandom;
      reg_wr(addr_t[i % 4], w);
      lat[i % 4] = w;
      ext0  <= $urandom;
      ext2  <= $urandom;
      ext3  <= $urandom;
      p1_in <= $urandom;
      settle();
      reg_rd(addr_t[i % 4], 1'b1, exp_pin(i % 4));
      cmp_byte(p0_oe_n, lat[0]);
      cmp_byte(port_one_analog_sel, lat[1]);
      cmp_byte(p2_oe_n, lat[2]);
      cmp_byte(p3_oe_n, lat[3]);
    end
    reg_wr(8'hC0, 8'h5A);
    reg_rd(8'h88, 1'b0, 8'h00);
    cmp_byte(p3_oe_n, lat[3]);
    // Alternate inputs with latch ones, then held off by zeros
    reg_wr(FPP_ADDR_PORT1, 8'hFF);
    reg_wr(FPP_ADDR_PORT3, 8'hFF);
    r1 = $urandom;
    r3 = $urandom;
    p1_in <= r1;
    ext3  <= r3;
    settle();
    cmp_byte({uart_rxd, periph},
             {r3[0], r1[0], r1[1], r1[5], r3[2], r3[3], r3[4], r3[5]});
    reg_wr(FPP_ADDR_PORT1, 8'h00);
    reg_wr(FPP_ADDR_PORT3, 8'h00);
    p1_in <= 8'hFF;
    ext3  <= 8'hFF;
    settle();
    cmp_byte({uart_rxd, periph}, 8'h00);
    cmp_byte(p3_in, 8'h00);
    // Strobes and UART own port three pins
    reg_wr(FPP_ADDR_PORT3, 8'hFF);
    {uart_en, uart_txd, uart_rxd_oe, uart_rxd_out} <= 4'b1010;
    {xmem_strobe_en, xmem_wr_n, xmem_rd_n} <= 3'b101;
    settle();
    cmp_byte(p3_in, 8'b1011_1100);
    @(posedge mclk);
    {uart_txd, uart_rxd_oe, xmem_wr_n, xmem_rd_n} <= 4'b1010;
    ext3 <= 8'hFE;
    settle();
    cmp_byte(p3_in, 8'b0111_1110);
    cmp_byte({7'h00, uart_rxd}, 8'h00);
    // External memory cycle overrides zero latches
    reg_wr(FPP_ADDR_PORT0, 8'h00);
    reg_wr(FPP_ADDR_PORT2, 8'h00);
    {xmem_p0_drive, xmem_p2_drive} <= 2'b11;
    // Outside parties release the bus while the core drives it
    ext0 <= 8'hFF;
    ext2 <= 8'hFF;
    xmem_p0_data <= $urandom;
    xmem_p2_addr <= $urandom;
    settle();
    cmp_byte(p0_oe_n, 8'h00);
    cmp_byte(p0_in, xmem_p0_data);
    cmp_byte(p2_in, xmem_p2_addr);
    @(posedge mclk);
    {xmem_p0_drive, xmem_p2_drive} <= 2'b00;
    settle();
    cmp_byte(p0_in, 8'h00);
    results();
  end
endmodule : four_port_parallel_io_tb_top

`default_nettype wire

// >>> fpp_ext_model.sv
// Far-side model: board wiring and outside drivers of the port zero, two and three pins
`timescale 1ns/100ps
`default_nettype none

module fpp_ext_model (
  input  wire logic [7:0] p0_out,
  input  wire logic [7:0] p0_oe_n,
  input  wire logic [7:0] p2_out,
  input  wire logic [7:0] p2_oe_n,
  input  wire logic [7:0] p3_out,
  input  wire logic [7:0] p3_oe_n,
  input  wire logic [7:0] ext0,
  input  wire logic [7:0] ext2,
  input  wire logic [7:0] ext3,
  output var  logic [7:0] p0_in,
  output var  logic [7:0] p2_in,
  output var  logic [7:0] p3_in
);
  // ------------------------------------------------------------
  // Wired-AND pin resolution
  // ------------------------------------------------------------
  // Outside parties only pull low (1 = released), so no contention.
  // Port zero floats when released; a board pull-up is fitted here,
  // otherwise its reads would be meaningless.
  always_comb begin
    p0_in = (p0_oe_n | p0_out) & ext0;
    p2_in = (p2_oe_n | p2_out) & ext2;
    p3_in = (p3_oe_n | p3_out) & ext3;
  end
endmodule : fpp_ext_model

`default_nettype wire

// >>> fpp_pin_if.sv
// Interface carrying raw and filtered pin levels between modules
`timescale 1ns/100ps
`default_nettype none

interface fpp_pin_if #(parameter int WIDTH = 32);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] filt;

  modport filter (input raw, output filt);
  modport user   (output raw, input filt);
endinterface : fpp_pin_if

`default_nettype wire

// >>> fpp_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none

module fpp_pin_sync #(
  parameter int WIDTH = 32
) (
  input  wire logic  mclk,
  input  wire logic  rst_n,
  fpp_pin_if.filter  pins
);
  import fpp_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] filt;
  } fpp_sync_st_t;

  fpp_sync_st_t st_r;
  fpp_sync_st_t st_nxt;

  // ------------------------------------------------------------
  // Filter: new level only once stages two and three agree
  // ------------------------------------------------------------
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = pins.raw;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.filt[i] = st_r.s3[i];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{default: '1};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pins.filt = st_r.filt;

endmodule : fpp_pin_sync

`default_nettype wire

// >>> fpp_pkg.sv
// Package with constants of the four-port parallel I/O block
package fpp_pkg;

  // ------------------------------------------------------------
  // Register addresses in special-function space
  // ------------------------------------------------------------
  localparam logic [7:0] FPP_ADDR_PORT0 = 8'h80;
  localparam logic [7:0] FPP_ADDR_PORT1 = 8'h90;
  localparam logic [7:0] FPP_ADDR_PORT2 = 8'hA0;
  localparam logic [7:0] FPP_ADDR_PORT3 = 8'hB0;

  // ------------------------------------------------------------
  // Latch reset values
  // ------------------------------------------------------------
  localparam logic [7:0] FPP_RST_PORT0 = 8'hFF;
  localparam logic [7:0] FPP_RST_PORT1 = 8'hFF;
  localparam logic [7:0] FPP_RST_PORT2 = 8'hFF;
  localparam logic [7:0] FPP_RST_PORT3 = 8'hFF;

  // ------------------------------------------------------------
  // Alternate-function bit positions
  // ------------------------------------------------------------
  localparam int FPP_PT1_TMR3_CNT  = 0;
  localparam int FPP_PT1_TMR3_TRIG = 1;
  localparam int FPP_PT1_SPI_SEL   = 5;
  localparam int FPP_PT3_RXD       = 0;
  localparam int FPP_PT3_TXD       = 1;
  localparam int FPP_PT3_EXTI_A    = 2;
  localparam int FPP_PT3_EXTI_B    = 3;
  localparam int FPP_PT3_TMR1_CNT  = 4;
  localparam int FPP_PT3_TMR2_CNT  = 5;
  localparam int FPP_PT3_WR_N      = 6;
  localparam int FPP_PT3_RD_N      = 7;

  // ------------------------------------------------------------
  // Pin filter
  // ------------------------------------------------------------
  localparam int FPP_SYNC_STAGES = 3;
  localparam int FPP_PIN_COUNT   = 32;

  typedef logic [7:0] fpp_byte_t;

endpackage : fpp_pkg

// >>> fpp_ports.sv
// Four 8-bit parallel ports with latches, alternate functions, bus mux
// Functional notes
// [RULE1] Port zero is an 8-bit open-drain port whose latch sits at 80H.
// [RULE2] A one in a port zero latch bit leaves that pin floating.
// [RULE3] In external memory cycles port zero drives address/data fully.
// [RULE4] Port one is input only, its latch at 90H, with no output drive.
// [RULE5] Port one latch resets to ones (analog); a zero selects digital.
// [RULE6] Port one bits 0, 1, 5 feed third timer count, trigger, SPI select.
// [RULE7] Port two has pull-ups, latch at A0H; a one lets the pin be input.
// [RULE8] Port two drives high, or middle and high, external address bytes.
// [RULE9] Port three has pull-ups, latch at B0H; a one lets pins be inputs.
// [RULE10] Port three bits 0 and 1 carry UART receive and transmit.
// [RULE11] Port three bits 2 and 3 feed external interrupts zero and one.
// [RULE12] Port three bits 4 and 5 feed first and second timer counts.
// [RULE13] Port three bits 6 and 7 carry external write and read strobes.
// [RULE14] Alternate functions work only with latch one, else pin is zero.
// [RULE15] An enabled peripheral takes a pin over from general I/O.
// [RULE16] Register write sets the latch, read returns sampled pin levels.
`timescale 1ns/100ps
`default_nettype none

module fpp_ports (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  // Core special-function access
  input  wire logic [7:0]   sfr_addr,
  input  wire logic         sfr_wr,
  input  wire logic         sfr_rd,
  input  wire fpp_pkg::fpp_byte_t sfr_wdata,
  output var  fpp_pkg::fpp_byte_t sfr_rdata,
  output var  logic         sfr_ack,
  // External memory bus from the core
  input  wire logic         xmem_p0_drive,
  input  wire logic [7:0]   xmem_p0_data,
  input  wire logic         xmem_p2_drive,
  input  wire logic [7:0]   xmem_p2_addr,
  input  wire logic         xmem_strobe_en,
  input  wire logic         xmem_wr_n,
  input  wire logic         xmem_rd_n,
  // UART
  input  wire logic         uart_en,
  input  wire logic         uart_txd,
  input  wire logic         uart_rxd_oe,
  input  wire logic         uart_rxd_out,
  output var  logic         uart_rxd,
  // Peripheral inputs
  output var  logic         third_timer_count_input,
  output var  logic         third_timer_capture_trigger,
  output var  logic         spi_slave_select_n,
  output var  logic         ext_interrupt_zero,
  output var  logic         ext_interrupt_one,
  output var  logic         first_timer_count_input,
  output var  logic         second_timer_count_input,
  output var  logic [7:0]   port_one_analog_sel,
  // Pins
  input  wire logic [7:0]   p0_in,
  output var  logic [7:0]   p0_out,
  output var  logic [7:0]   p0_oe_n,
  input  wire logic [7:0]   p1_in,
  input  wire logic [7:0]   p2_in,
  output var  logic [7:0]   p2_out,
  output var  logic [7:0]   p2_oe_n,
  input  wire logic [7:0]   p3_in,
  output var  logic [7:0]   p3_out,
  output var  logic [7:0]   p3_oe_n
);
  import fpp_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] port_zero_latch;
    logic [7:0] port_one_latch;
    logic [7:0] port_two_latch;
    logic [7:0] port_three_latch;
    logic [7:0] rdata;
    logic       ack;
    logic [7:0] p0_out;
    logic [7:0] p0_oe_n;
    logic [7:0] p2_out;
    logic [7:0] p2_oe_n;
    logic [7:0] p3_out;
    logic [7:0] p3_oe_n;
    logic [7:0] ana;
    logic       rxd;
    logic       tmr3_cnt;
    logic       tmr3_trig;
    logic       ss_n;
    logic       exti_a;
    logic       exti_b;
    logic       tmr1_cnt;
    logic       tmr2_cnt;
  } fpp_state_t;

  fpp_state_t st_r;
  fpp_state_t st_nxt;

  // ------------------------------------------------------------
  // Pin synchroniser
  // ------------------------------------------------------------
  fpp_pin_if #(.WIDTH(FPP_PIN_COUNT)) pins ();

  assign pins.raw = {p3_in, p2_in, p1_in, p0_in};

  fpp_pin_sync #(.WIDTH(FPP_PIN_COUNT)) u_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .pins  (pins.filter)
  );

  logic [7:0] p0_s;
  logic [7:0] p1_s;
  logic [7:0] p2_s;
  logic [7:0] p3_s;

  assign p0_s = pins.filt[7:0];
  assign p1_s = pins.filt[15:8];
  assign p2_s = pins.filt[23:16];
  assign p3_s = pins.filt[31:24];

  // Alternate inputs read zero while their latch bit is zero
  logic [7:0] p1_alt;
  logic [7:0] p3_alt;

  assign p1_alt = p1_s & st_r.port_one_latch;   // [RULE14]
  assign p3_alt = p3_s & st_r.port_three_latch; // [RULE14]

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    st_nxt     = st_r;
    st_nxt.ack = 1'b0;

    // Latch writes
    if (sfr_wr) begin
      case (sfr_addr)
        FPP_ADDR_PORT0: st_nxt.port_zero_latch  = sfr_wdata; // [RULE1] [RULE16]
        FPP_ADDR_PORT1: st_nxt.port_one_latch   = sfr_wdata; // [RULE4] [RULE16]
        FPP_ADDR_PORT2: st_nxt.port_two_latch   = sfr_wdata; // [RULE7] [RULE16]
        FPP_ADDR_PORT3: st_nxt.port_three_latch = sfr_wdata; // [RULE9] [RULE16]
        default: ;
      endcase
    end

    // Reads return pin levels, not latch contents
    if (sfr_rd) begin
      st_nxt.ack = 1'b1;
      case (sfr_addr)
        FPP_ADDR_PORT0: st_nxt.rdata = p0_s; // [RULE16]
        FPP_ADDR_PORT1: st_nxt.rdata = p1_s; // [RULE16]
        FPP_ADDR_PORT2: st_nxt.rdata = p2_s; // [RULE16]
        FPP_ADDR_PORT3: st_nxt.rdata = p3_s; // [RULE16]
        default: begin
          st_nxt.rdata = 8'h00;
          st_nxt.ack   = 1'b0;
        end
      endcase
    end

    // Port zero: open drain, full drive only as memory bus
    if (xmem_p0_drive) begin
      st_nxt.p0_out  = xmem_p0_data; // [RULE3]
      st_nxt.p0_oe_n = 8'h00;        // [RULE3]
    end else begin
      st_nxt.p0_out  = 8'h00;
      st_nxt.p0_oe_n = st_r.port_zero_latch; // [RULE1] [RULE2]
    end

    // Port one: latch selects analog, never drives
    st_nxt.ana = st_r.port_one_latch; // [RULE4] [RULE5]

    // Port two: pull-up pin, driven low by a zero latch
    if (xmem_p2_drive) begin
      st_nxt.p2_out  = xmem_p2_addr; // [RULE8]
      st_nxt.p2_oe_n = 8'h00;        // [RULE8]
    end else begin
      st_nxt.p2_out  = 8'h00;
      st_nxt.p2_oe_n = st_r.port_two_latch; // [RULE7]
    end

    // Port three: general I/O first, then peripheral overrides
    st_nxt.p3_out  = 8'h00;
    st_nxt.p3_oe_n = st_r.port_three_latch; // [RULE9]
    if (uart_en && st_r.port_three_latch[FPP_PT3_TXD]) begin
      // Pull-up pin: drive only the low level of transmit
      st_nxt.p3_out[FPP_PT3_TXD]  = 1'b0;           // [RULE10] [RULE15]
      st_nxt.p3_oe_n[FPP_PT3_TXD] = uart_txd;       // [RULE10] [RULE15]
    end
    if (uart_en && uart_rxd_oe && st_r.port_three_latch[FPP_PT3_RXD]) begin
      st_nxt.p3_out[FPP_PT3_RXD]  = 1'b0;           // [RULE10] [RULE15]
      st_nxt.p3_oe_n[FPP_PT3_RXD] = uart_rxd_out;   // [RULE10] [RULE15]
    end
    if (xmem_strobe_en && st_r.port_three_latch[FPP_PT3_WR_N]) begin
      // Strobes driven both ways for clean edges
      st_nxt.p3_out[FPP_PT3_WR_N]  = xmem_wr_n;     // [RULE13] [RULE15]
      st_nxt.p3_oe_n[FPP_PT3_WR_N] = 1'b0;          // [RULE13]
    end
    if (xmem_strobe_en && st_r.port_three_latch[FPP_PT3_RD_N]) begin
      st_nxt.p3_out[FPP_PT3_RD_N]  = xmem_rd_n;     // [RULE13] [RULE15]
      st_nxt.p3_oe_n[FPP_PT3_RD_N] = 1'b0;          // [RULE13]
    end

    // Alternate inputs: zero unless latch holds one
    st_nxt.tmr3_cnt  = p1_alt[FPP_PT1_TMR3_CNT];  // [RULE6] [RULE14]
    st_nxt.tmr3_trig = p1_alt[FPP_PT1_TMR3_TRIG]; // [RULE6] [RULE14]
    st_nxt.ss_n      = p1_alt[FPP_PT1_SPI_SEL];   // [RULE6] [RULE14]
    st_nxt.rxd       = p3_alt[FPP_PT3_RXD];       // [RULE10] [RULE14]
    st_nxt.exti_a    = p3_alt[FPP_PT3_EXTI_A];    // [RULE11] [RULE14]
    st_nxt.exti_b    = p3_alt[FPP_PT3_EXTI_B];    // [RULE11] [RULE14]
    st_nxt.tmr1_cnt  = p3_alt[FPP_PT3_TMR1_CNT];  // [RULE12] [RULE14]
    st_nxt.tmr2_cnt  = p3_alt[FPP_PT3_TMR2_CNT];  // [RULE12] [RULE14]
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r                  <= '0;
      st_r.port_zero_latch  <= FPP_RST_PORT0;
      st_r.port_one_latch   <= FPP_RST_PORT1; // [RULE5]
      st_r.port_two_latch   <= FPP_RST_PORT2;
      st_r.port_three_latch <= FPP_RST_PORT3;
      st_r.p0_oe_n          <= 8'hFF;
      st_r.p2_oe_n          <= 8'hFF;
      st_r.p3_oe_n          <= 8'hFF;
      st_r.ana              <= FPP_RST_PORT1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign sfr_rdata                   = st_r.rdata;
  assign sfr_ack                     = st_r.ack;
  assign p0_out                      = st_r.p0_out;
  assign p0_oe_n                     = st_r.p0_oe_n;
  assign p2_out                      = st_r.p2_out;
  assign p2_oe_n                     = st_r.p2_oe_n;
  assign p3_out                      = st_r.p3_out;
  assign p3_oe_n                     = st_r.p3_oe_n;
  assign port_one_analog_sel         = st_r.ana;
  assign uart_rxd                    = st_r.rxd;
  assign third_timer_count_input     = st_r.tmr3_cnt;
  assign third_timer_capture_trigger = st_r.tmr3_trig;
  assign spi_slave_select_n          = st_r.ss_n;
  assign ext_interrupt_zero          = st_r.exti_a;
  assign ext_interrupt_one           = st_r.exti_b;
  assign first_timer_count_input     = st_r.tmr1_cnt;
  assign second_timer_count_input    = st_r.tmr2_cnt;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  chk_p0_open_drain: assert property ( // [RULE2]
    !xmem_p0_drive ##1 !xmem_p0_drive |=>
      p0_oe_n == $past(st_r.port_zero_latch) && p0_out == 8'h00)
    else $error("port zero not open drain");

  chk_p0_bus_drive: assert property ( // [RULE3]
    xmem_p0_drive |=> p0_oe_n == 8'h00 && p0_out == $past(xmem_p0_data))
    else $error("port zero bus not driven");

  chk_p1_analog_sel: assert property ( // [RULE5]
    sfr_wr && sfr_addr == FPP_ADDR_PORT1 |=>
      ##1 port_one_analog_sel == $past(sfr_wdata, 2))
    else $error("port one select wrong");

  chk_p2_addr_out: assert property ( // [RULE8]
    xmem_p2_drive |=> p2_oe_n == 8'h00 && p2_out == $past(xmem_p2_addr))
    else $error("port two address wrong");

  chk_p2_pullup: assert property ( // [RULE7]
    sfr_wr && sfr_addr == FPP_ADDR_PORT2 && !xmem_p2_drive ##1
      !xmem_p2_drive |=> p2_oe_n == $past(sfr_wdata, 2))
    else $error("port two latch not applied");

  chk_alt_gated: assert property ( // [RULE14]
    !st_r.port_three_latch[FPP_PT3_EXTI_A] |=> !ext_interrupt_zero)
    else $error("interrupt input not gated");

  chk_txd_pin: assert property ( // [RULE10]
    uart_en && st_r.port_three_latch[FPP_PT3_TXD] |=>
      p3_oe_n[FPP_PT3_TXD] == $past(uart_txd) && !p3_out[FPP_PT3_TXD])
    else $error("transmit pin wrong");

  chk_wr_strobe: assert property ( // [RULE13]
    xmem_strobe_en && st_r.port_three_latch[FPP_PT3_WR_N] |=>
      !p3_oe_n[FPP_PT3_WR_N] && p3_out[FPP_PT3_WR_N] == $past(xmem_wr_n))
    else $error("write strobe wrong");

  chk_read_pins: assert property ( // [RULE16]
    sfr_rd && sfr_addr == FPP_ADDR_PORT3 |=>
      sfr_ack && sfr_rdata == $past(p3_s))
    else $error("port read wrong");

  cov_bus_cycle:  cover property (xmem_p0_drive ##1 xmem_p2_drive);
  cov_p1_digital: cover property (
    sfr_wr && sfr_addr == FPP_ADDR_PORT1 && sfr_wdata == 8'h00);
  cov_uart_tx:    cover property (uart_en ##1 p3_oe_n[FPP_PT3_TXD] == 1'b0);
  cov_pin_read:   cover property (sfr_rd ##1 sfr_ack);

endmodule : fpp_ports

`default_nettype wire
